// ==== vlt_integrator.sv ====
/*
 * Clamped velocity loop integrator, stepped once per loop sample.
 * Assumes gain and limit are already held stable between samples.
 */
`timescale 1ns/1ps
module vlt_integrator (
	input  wire logic                 sys_clk,
	input  wire logic                 rstn,
	input  wire logic                 sampleTick,
	input  wire logic signed [15:0]   velError,
	input  wire logic        [16:0]   kiEff,
	input  wire logic        [15:0]   limit,
	output logic signed      [16:0]   integralOut
);
	import vlt_pkg::*;

	logic signed [34:0] stepFull;
	logic signed [34:0] sumWide;
	logic signed [34:0] limPos;
	logic signed [16:0] integralNext;

	// Fine gain weighs one part in 32 of the main gain
	assign stepFull = 35'(velError * $signed({1'b0, kiEff})) >>> KI_MAIN_SHIFT;
	assign sumWide  = 35'(integralOut) + stepFull;
	assign limPos   = 35'($signed({1'b0, limit}));
	// Limit of +2^15 does not fit in 16 signed bits, hence the 17-bit output
	assign integralNext = (sumWide > limPos)  ? 17'(limPos) :
	                      (sumWide < -limPos) ? 17'(-limPos) : 17'(sumWide);

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			integralOut <= 17'sh0;
		end else if (sampleTick) begin
			integralOut <= integralNext;
		end
	end

	property p_int_clamp;
		@(posedge sys_clk) disable iff (!rstn)
		sampleTick |=> (integralOut <= $signed({1'b0, $past(limit)}))
			&& (integralOut >= -$signed({1'b0, $past(limit)}));
	endproperty
	a_int_clamp: assert property (p_int_clamp) else $error("integral exceeds clamp");

	property p_int_hold;
		@(posedge sys_clk) disable iff (!rstn)
		!sampleTick |=> $stable(integralOut);
	endproperty
	a_int_hold: assert property (p_int_hold) else $error("integral moved off tick");
endmodule : vlt_integrator

// ==== vlt_pkg.sv ====
/*
 * Shared constants and types for the velocity loop tuning block.
 * Assumes a 100 MHz sys_clk and a single synchronous reset domain.
 */
package vlt_pkg;
	typedef logic [23:0] vlt_addr_t;
	typedef logic [15:0] vlt_word_t;

	// Register addresses
	localparam vlt_addr_t OFS_AUTOTUNE_CTL = 24'h234010;
	localparam vlt_addr_t OFS_VEL_BW       = 24'h2ff00a;
	localparam vlt_addr_t OFS_KI_COMBINED  = 24'h2ff019;
	localparam vlt_addr_t OFS_KP           = 24'h60f901;
	localparam vlt_addr_t OFS_KI_MAIN      = 24'h60f902;
	localparam vlt_addr_t OFS_FB_FILTER    = 24'h60f905;
	localparam vlt_addr_t OFS_FB_SELECT    = 24'h60f906;
	localparam vlt_addr_t OFS_KI_FINE      = 24'h60f907;
	localparam vlt_addr_t OFS_INT_CLAMP    = 24'h60f908;
	localparam vlt_addr_t OFS_OUT_FILTER   = 24'h60f915;

	// Reset values
	localparam logic [7:0] RST_AUTOTUNE_CTL = 8'h0c;
	localparam vlt_word_t  RST_VEL_BW       = 16'h0032;
	localparam vlt_word_t  RST_KP           = 16'h0064;
	localparam vlt_word_t  RST_KI_MAIN      = 16'h000a;
	localparam vlt_word_t  RST_KI_FINE      = 16'h0000;
	localparam logic [7:0] RST_FB_FILTER    = 8'h07;
	localparam logic [7:0] RST_FB_SELECT    = 8'h00;
	localparam vlt_word_t  RST_INT_CLAMP    = 16'h1000;
	localparam vlt_word_t  RST_OUT_FILTER   = 16'h0001;

	// Accepted ranges
	localparam logic [7:0] AUTOTUNE_MAX = 8'h1f;
	localparam vlt_word_t  VEL_BW_MIN   = 16'h0001;
	localparam vlt_word_t  VEL_BW_MAX   = 16'h02bc;
	localparam vlt_word_t  KP_MIN       = 16'h0001;
	localparam vlt_word_t  KP_MAX       = 16'h7fff;
	localparam vlt_word_t  KI_MAIN_MAX  = 16'h03ff;
	localparam vlt_word_t  KI_FINE_MAX  = 16'h7fff;
	localparam vlt_word_t  KI_MIX_MAX   = 16'h4000;
	localparam vlt_word_t  FB_FILT_MAX  = 16'h002d;
	localparam vlt_word_t  OUT_FILT_MIN = 16'h0001;
	localparam vlt_word_t  OUT_FILT_MAX = 16'h055a;
	localparam vlt_word_t  INT_CLAMP_MAX = 16'h8000;

	// Control bit positions
	localparam int BIT_EST_EN     = 0;
	localparam int BIT_KP_AUTO    = 1;
	localparam int BIT_ACCFF_AUTO = 2;
	localparam int BIT_NO_FWD     = 4;
	localparam int BIT_NO_REV     = 5;
	localparam int BIT_FRICTION   = 7;
	localparam int BIT_FAST_RATE  = 7;

	// Feedback mode codes held in bits 6:0
	localparam logic [6:0] MODE_LPF2     = 7'h00;
	localparam logic [6:0] MODE_RAW      = 7'h01;
	localparam logic [6:0] MODE_OBS      = 7'h02;
	localparam logic [6:0] MODE_LPF1     = 7'h04;
	localparam logic [6:0] MODE_LPF2_CMD = 7'h0a;
	localparam logic [6:0] MODE_RAW_CMD  = 7'h0b;
	localparam logic [6:0] MODE_OBS_CMD  = 7'h0c;
	localparam logic [6:0] MODE_LPF1_CMD = 7'h0e;

	// Arithmetic constants
	localparam vlt_word_t FB_BW_BASE_HZ = 16'h0064;
	localparam vlt_word_t FB_BW_STEP_HZ = 16'h0014;
	localparam int        KI_MAIN_SHIFT = 5;
	localparam int        KP_BW_SHIFT   = 3;

	// Loop rates
	localparam int CLK_HZ          = 100_000_000;
	localparam int VEL_RATE_LO_HZ  = 4000;
	localparam int VEL_RATE_HI_HZ  = 8000;
	localparam int VEL_CYC_LO      = CLK_HZ / VEL_RATE_LO_HZ;
	localparam int VEL_CYC_HI      = CLK_HZ / VEL_RATE_HI_HZ;
	localparam logic [1:0] POS_DIV_LAST = 2'h3;

	typedef enum logic [1:0] {FB_PATH_LPF2, FB_PATH_RAW, FB_PATH_OBS, FB_PATH_LPF1} vlt_fb_path_t;

	typedef struct packed {
		vlt_addr_t addr;
		vlt_word_t wdata;
		logic      wr;
		logic      rd;
	} vlt_bus_req_t;

	typedef struct packed {
		vlt_word_t    kp;
		logic [16:0]  kiEff;
		vlt_word_t    intLimit;
		vlt_word_t    fbBandwidthHz;
		vlt_word_t    outFilterDiv;
		vlt_fb_path_t fbPath;
		logic         cmdFilterOn;
		logic         cmdSharesFbBw;
		logic         fastRate;
	} vlt_loop_cfg_t;
endpackage : vlt_pkg

// ==== vlt_velocity_loop_cfg.sv ====
/*
 * Velocity loop parameter registers, sample-rate timing and online
 * self-tuning control. Assumes a plain register port with one-cycle
 * strobes and an external estimator that reports tuned gains.
 */
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Control bit 0 enables online inertia estimation while the axis moves.
// - Control bit 1 lets a finished self-tune overwrite the proportional gain.
// - Control bit 2 enables automatic acceleration feedforward retuning.
// - Bit 4 suspends tuning moving forward, bit 5 moving in reverse.
// - Control bit 7 drives the friction flag, but control writes above 31 are dropped, so it stays clear.
// - Control object resets to 12, takes 0 to 31, reads and writes.
// - Fine integral gain weighs one thirty-second of the main integral gain.
// - Combined gain reads main times 32 plus fine, limited to 16384.
// - Writing combined gain zeroes main gain and loads the fine gain.
// - Feedback bandwidth is 100 plus 20 times setting; 0 to 45, reset 7.
// - Mode 0 second-order, 1 raw, 2 observer, 4 first-order lowpass.
// - Modes 10, 11, 12, 14 filter the command; 10 and 14 share bandwidth.
// - Mode bit 7 picks 8K/2K sampling, otherwise 4K/1K.
// - Bandwidth write, 1 to 700, recomputes proportional gain from inertia ratio.
// - Proportional gain takes 1 to 32767 and sets loop response.
// - Main integral gain takes 0 to 1023.
// - Forward-path torque lowpass divisor takes values up to 1370.
// - Integral output is clamped to the limit setting, 0 to 2^15.
module vlt_velocity_loop_cfg #(
	parameter int VEL_CYC_LO_P = vlt_pkg::VEL_CYC_LO,
	parameter int VEL_CYC_HI_P = vlt_pkg::VEL_CYC_HI
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rstn,
	input  wire vlt_pkg::vlt_bus_req_t  busReq,
	output logic [15:0]                 rdData,
	input  wire logic [15:0]            inertiaRatio,
	input  wire logic                   moveFwd,
	input  wire logic                   moveRev,
	input  wire logic                   tuneKpValid,
	input  wire logic [15:0]            tuneKp,
	input  wire logic signed [15:0]     velError,
	output vlt_pkg::vlt_loop_cfg_t      cfg,
	output logic                        velTick,
	output logic                        posTick,
	output logic                        estimateEn,
	output logic                        kpAutoEn,
	output logic                        accFfAutoEn,
	output logic                        frictionEn,
	output logic signed [16:0]          integralOut
);
	import vlt_pkg::*;

	function automatic vlt_word_t clampW(input vlt_word_t v, input vlt_word_t lo,
		input vlt_word_t hi);
		clampW = (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction : clampW

	logic [7:0]    autotuneCtlReg;
	vlt_word_t     velBwReg;
	vlt_word_t     kpReg;
	vlt_word_t     kiMainReg;
	vlt_word_t     kiFineReg;
	logic [7:0]    fbFilterReg;
	logic [7:0]    fbSelectReg;
	vlt_word_t     intClampReg;
	vlt_word_t     outFilterReg;
	logic [14:0]   tickCntReg;
	logic [1:0]    posDivReg;

	// Address decode
	wire vlt_word_t wd        = busReq.wdata;
	wire wrCtl      = busReq.wr && (busReq.addr == OFS_AUTOTUNE_CTL);
	wire wrBw       = busReq.wr && (busReq.addr == OFS_VEL_BW);
	wire wrMix      = busReq.wr && (busReq.addr == OFS_KI_COMBINED);
	wire wrKp       = busReq.wr && (busReq.addr == OFS_KP);
	wire wrKiMain   = busReq.wr && (busReq.addr == OFS_KI_MAIN);
	wire wrFbFilt   = busReq.wr && (busReq.addr == OFS_FB_FILTER);
	wire wrFbSel    = busReq.wr && (busReq.addr == OFS_FB_SELECT);
	wire wrKiFine   = busReq.wr && (busReq.addr == OFS_KI_FINE);
	wire wrClamp    = busReq.wr && (busReq.addr == OFS_INT_CLAMP);
	wire wrOutFilt  = busReq.wr && (busReq.addr == OFS_OUT_FILTER);

	// Out-of-range control writes are dropped so stray bits cannot arm tuning
	wire ctlInRange = (wd[15:8] == 8'h00) && (wd[7:0] <= AUTOTUNE_MAX);
	wire [7:0] autotuneCtlNext = (wrCtl && ctlInRange) ? wd[7:0] : autotuneCtlReg;

	// Bandwidth write rescales the gain by the present inertia ratio
	wire vlt_word_t velBwClamped = clampW(wd, VEL_BW_MIN, VEL_BW_MAX);
	wire [31:0] bwProd   = 32'(velBwClamped) * 32'(inertiaRatio);
	wire [31:0] bwScaled = bwProd >> KP_BW_SHIFT;
	wire vlt_word_t kpFromBw = (bwScaled > 32'(KP_MAX)) ? KP_MAX :
	                           (bwScaled < 32'(KP_MIN)) ? KP_MIN : bwScaled[15:0];
	wire kpTuneTake = tuneKpValid && autotuneCtlReg[BIT_KP_AUTO];

	// Host write wins over a bandwidth recompute, which wins over the tuner
	wire vlt_word_t kpNext = wrKp ? clampW(wd, KP_MIN, KP_MAX) :
	                         wrBw ? kpFromBw :
	                         kpTuneTake ? clampW(tuneKp, KP_MIN, KP_MAX) : kpReg;
	wire vlt_word_t velBwNext   = wrBw ? velBwClamped : velBwReg;
	wire vlt_word_t kiMainNext  = wrKiMain ? clampW(wd, 16'h0000, KI_MAIN_MAX) :
	                              wrMix ? 16'h0000 : kiMainReg;
	wire vlt_word_t kiFineNext  = wrKiFine ? clampW(wd, 16'h0000, KI_FINE_MAX) :
	                              wrMix ? clampW(wd, 16'h0000, KI_MIX_MAX) : kiFineReg;
	// Clamp keeps the setting under 46, so the cut to 8 bits drops only zeros
	wire [7:0] fbFilterNext = wrFbFilt ? 8'(clampW(wd, 16'h0000, FB_FILT_MAX))
		: fbFilterReg;
	wire [7:0] fbSelectNext  = wrFbSel ? wd[7:0] : fbSelectReg;
	wire vlt_word_t intClampNext  = wrClamp ? clampW(wd, 16'h0000, INT_CLAMP_MAX)
		: intClampReg;
	wire vlt_word_t outFilterNext = wrOutFilt ? clampW(wd, OUT_FILT_MIN, OUT_FILT_MAX)
		: outFilterReg;

	// Combined integral gain view
	wire [16:0] kiMixSum   = {kiMainReg[11:0], 5'h00} + {1'b0, kiFineReg};
	wire vlt_word_t kiMixRead = (kiMixSum > 17'(KI_MIX_MAX)) ? KI_MIX_MAX : kiMixSum[15:0];

	wire vlt_word_t rdMux =
		(busReq.addr == OFS_AUTOTUNE_CTL) ? {8'h00, autotuneCtlReg} :
		(busReq.addr == OFS_VEL_BW)       ? velBwReg :
		(busReq.addr == OFS_KI_COMBINED)  ? kiMixRead :
		(busReq.addr == OFS_KP)           ? kpReg :
		(busReq.addr == OFS_KI_MAIN)      ? kiMainReg :
		(busReq.addr == OFS_FB_FILTER)    ? {8'h00, fbFilterReg} :
		(busReq.addr == OFS_FB_SELECT)    ? {8'h00, fbSelectReg} :
		(busReq.addr == OFS_KI_FINE)      ? kiFineReg :
		(busReq.addr == OFS_INT_CLAMP)    ? intClampReg :
		(busReq.addr == OFS_OUT_FILTER)   ? outFilterReg : 16'h0000;

	// Feedback mode decode; unknown codes fall back to the reset path
	wire [6:0] modeCode = fbSelectReg[6:0];
	wire vlt_fb_path_t fbPathDec =
		(modeCode == MODE_RAW  || modeCode == MODE_RAW_CMD)  ? FB_PATH_RAW :
		(modeCode == MODE_OBS  || modeCode == MODE_OBS_CMD)  ? FB_PATH_OBS :
		(modeCode == MODE_LPF1 || modeCode == MODE_LPF1_CMD) ? FB_PATH_LPF1 :
		FB_PATH_LPF2;
	wire cmdFilterDec = (modeCode == MODE_LPF2_CMD) || (modeCode == MODE_RAW_CMD) ||
	                    (modeCode == MODE_OBS_CMD) || (modeCode == MODE_LPF1_CMD);
	wire cmdShareDec  = (modeCode == MODE_LPF2_CMD) || (modeCode == MODE_LPF1_CMD);
	wire vlt_word_t fbBwHz = FB_BW_BASE_HZ + 16'({8'h00, fbFilterReg} * FB_BW_STEP_HZ);

	wire vlt_loop_cfg_t cfgNext = '{
		kp:            kpReg,
		kiEff:         kiMixSum,
		intLimit:      intClampReg,
		fbBandwidthHz: fbBwHz,
		outFilterDiv:  outFilterReg,
		fbPath:        fbPathDec,
		cmdFilterOn:   cmdFilterDec,
		cmdSharesFbBw: cmdShareDec,
		fastRate:      fbSelectReg[BIT_FAST_RATE]
	};

	// Sample timing follows the active rate so a rate switch lands on a boundary
	wire [14:0] tickLast = cfg.fastRate ? 15'(VEL_CYC_HI_P - 1) : 15'(VEL_CYC_LO_P - 1);
	wire        tickEnd  = (tickCntReg >= tickLast);
	wire [14:0] tickCntNext = tickEnd ? 15'h0000 : tickCntReg + 15'h0001;
	wire        posEnd   = tickEnd && (posDivReg == POS_DIV_LAST);

	// Tuning gate: suspended in a direction the host has excluded
	wire estimateNext = autotuneCtlReg[BIT_EST_EN] && (moveFwd || moveRev) &&
		!(moveFwd && autotuneCtlReg[BIT_NO_FWD]) &&
		!(moveRev && autotuneCtlReg[BIT_NO_REV]);

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			autotuneCtlReg <= RST_AUTOTUNE_CTL;
			velBwReg       <= RST_VEL_BW;
			kpReg          <= RST_KP;
			kiMainReg      <= RST_KI_MAIN;
			kiFineReg      <= RST_KI_FINE;
			fbFilterReg    <= RST_FB_FILTER;
			fbSelectReg    <= RST_FB_SELECT;
			intClampReg    <= RST_INT_CLAMP;
			outFilterReg   <= RST_OUT_FILTER;
		end else begin
			autotuneCtlReg <= autotuneCtlNext;
			velBwReg       <= velBwNext;
			kpReg          <= kpNext;
			kiMainReg      <= kiMainNext;
			kiFineReg      <= kiFineNext;
			fbFilterReg    <= fbFilterNext;
			fbSelectReg    <= fbSelectNext;
			intClampReg    <= intClampNext;
			outFilterReg   <= outFilterNext;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rdData <= 16'h0000;
		end else begin
			rdData <= busReq.rd ? rdMux : 16'h0000;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			tickCntReg <= 15'h0000;
			posDivReg  <= 2'h0;
			velTick    <= 1'b0;
			posTick    <= 1'b0;
			cfg        <= '0;
		end else begin
			tickCntReg <= tickCntNext;
			posDivReg  <= tickEnd ? posDivReg + 2'h1 : posDivReg;
			velTick    <= tickEnd;
			posTick    <= posEnd;
			if (tickEnd) begin
				cfg <= cfgNext;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			estimateEn  <= 1'b0;
			kpAutoEn    <= 1'b0;
			accFfAutoEn <= 1'b0;
			frictionEn  <= 1'b0;
		end else begin
			estimateEn  <= estimateNext;
			kpAutoEn    <= autotuneCtlReg[BIT_KP_AUTO];
			accFfAutoEn <= autotuneCtlReg[BIT_ACCFF_AUTO];
			frictionEn  <= autotuneCtlReg[BIT_FRICTION];
		end
	end

	vlt_integrator u_integrator (
		.sys_clk     (sys_clk),
		.rstn        (rstn),
		.sampleTick  (velTick),
		.velError    (velError),
		.kiEff       (cfg.kiEff),
		.limit       (cfg.intLimit),
		.integralOut (integralOut)
	);

	// Checking helpers
	logic [15:0] gapCntReg;
	logic        seenTickReg;
	logic        rateAtTickReg;
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			gapCntReg     <= 16'h0000;
			seenTickReg   <= 1'b0;
			rateAtTickReg <= 1'b0;
		end else begin
			gapCntReg     <= velTick ? 16'h0001 : gapCntReg + 16'h0001;
			seenTickReg   <= seenTickReg || velTick;
			rateAtTickReg <= velTick ? cfg.fastRate : rateAtTickReg;
		end
	end

	property p_ctl_write;
		@(posedge sys_clk) disable iff (!rstn)
		(wrCtl && ctlInRange) |=> (autotuneCtlReg == $past(wd[7:0]));
	endproperty
	a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

	property p_mix_write;
		@(posedge sys_clk) disable iff (!rstn)
		(wrMix && !wrKiMain) |=> (kiMainReg == 16'h0000) && (kiFineReg <= KI_MIX_MAX);
	endproperty
	a_mix_write: assert property (p_mix_write) else $error("combined write wrong");

	property p_mix_read;
		@(posedge sys_clk) disable iff (!rstn)
		(busReq.rd && busReq.addr == OFS_KI_COMBINED) |=> (rdData == $past(kiMixRead));
	endproperty
	a_mix_read: assert property (p_mix_read) else $error("combined read wrong");

	property p_gain_ranges;
		@(posedge sys_clk) disable iff (!rstn)
		(kiMainReg <= KI_MAIN_MAX) && (kpReg >= KP_MIN) && (kpReg <= KP_MAX);
	endproperty
	a_gain_ranges: assert property (p_gain_ranges) else $error("gain out of range");

	property p_bw_recalc;
		@(posedge sys_clk) disable iff (!rstn)
		(wrBw && !wrKp) |=> (kpReg == $past(kpFromBw));
	endproperty
	a_bw_recalc: assert property (p_bw_recalc) else $error("bandwidth did not set gain");

	property p_cfg_boundary;
		@(posedge sys_clk) disable iff (!rstn)
		!$stable(cfg) |-> velTick;
	endproperty
	a_cfg_boundary: assert property (p_cfg_boundary) else $error("cfg changed mid-sample");

	property p_rate;
		@(posedge sys_clk) disable iff (!rstn)
		(velTick && seenTickReg) |->
			(gapCntReg == 16'(rateAtTickReg ? VEL_CYC_HI_P : VEL_CYC_LO_P));
	endproperty
	a_rate: assert property (p_rate) else $error("sample period wrong");

	property p_share;
		@(posedge sys_clk) disable iff (!rstn)
		cfg.cmdSharesFbBw |-> cfg.cmdFilterOn && (cfg.fbPath != FB_PATH_RAW);
	endproperty
	a_share: assert property (p_share) else $error("shared bandwidth without filter");

	property p_suspend;
		@(posedge sys_clk) disable iff (!rstn)
		((moveFwd && autotuneCtlReg[BIT_NO_FWD]) || (moveRev && autotuneCtlReg[BIT_NO_REV]))
			|=> !estimateEn;
	endproperty
	a_suspend: assert property (p_suspend) else $error("tuning not suspended");

	property p_fb_bw;
		@(posedge sys_clk) disable iff (!rstn)
		velTick |-> (cfg.fbBandwidthHz == $past(fbBwHz));
	endproperty
	a_fb_bw: assert property (p_fb_bw) else $error("feedback bandwidth wrong");

	property p_tune_kp;
		@(posedge sys_clk) disable iff (!rstn)
		(kpTuneTake && !wrKp && !wrBw) |=> (kpReg == clampW($past(tuneKp), KP_MIN, KP_MAX));
	endproperty
	a_tune_kp: assert property (p_tune_kp) else $error("tuned gain not taken");

	// Tuner results must be ignored while automatic gain update is off
	property p_tune_off;
		@(posedge sys_clk) disable iff (!rstn)
		(tuneKpValid && !autotuneCtlReg[BIT_KP_AUTO] && !wrKp && !wrBw) |=> $stable(kpReg);
	endproperty
	a_tune_off: assert property (p_tune_off) else $error("tuned gain taken while off");

	// Guarded by the previous reset level: flags clear while control resets to 12
	property p_flags;
		@(posedge sys_clk) disable iff (!rstn)
		$past(rstn) |-> (accFfAutoEn == $past(autotuneCtlReg[BIT_ACCFF_AUTO]))
			&& (frictionEn == $past(autotuneCtlReg[BIT_FRICTION]));
	endproperty
	a_flags: assert property (p_flags) else $error("tuning flag wrong");

	property p_pos_tick;
		@(posedge sys_clk) disable iff (!rstn)
		posTick |-> velTick;
	endproperty
	a_pos_tick: assert property (p_pos_tick) else $error("position tick off boundary");

	property p_kp_write;
		@(posedge sys_clk) disable iff (!rstn)
		wrKp |=> (kpReg == clampW($past(wd), KP_MIN, KP_MAX));
	endproperty
	a_kp_write: assert property (p_kp_write) else $error("gain write wrong");

	c_mix_write: cover property (@(posedge sys_clk) disable iff (!rstn)
		wrMix ##1 (kiMainReg == 16'h0000));
	c_fast_rate: cover property (@(posedge sys_clk) disable iff (!rstn) velTick && cfg.fastRate);
	c_tune_kp:   cover property (@(posedge sys_clk) disable iff (!rstn) kpTuneTake);
	c_suspend:   cover property (@(posedge sys_clk) disable iff (!rstn)
		autotuneCtlReg[BIT_EST_EN] && moveRev && autotuneCtlReg[BIT_NO_REV]);
endmodule : vlt_velocity_loop_cfg

// ==== vlt_velocity_loop_cfg_tb.sv ====
/*
 * Self-checking bench for the velocity loop tuning configuration block.
 * Assumes the block's own assertions sit inside its design files.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin miscompares++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module vlt_velocity_loop_cfg_tb;
	import vlt_pkg::*;
	logic               sys_clk = 1'b0;
	logic               rstn = 1'b0;
	vlt_bus_req_t       busReq = '0;
	logic [15:0]        rdData;
	logic [15:0]        inertiaRatio = 16'h001e;
	logic               moveFwd = 1'b0;
	logic               moveRev = 1'b0;
	logic               tuneKpValid = 1'b0;
	logic [15:0]        tuneKp = 16'h0000;
	logic signed [15:0] velError = 16'sh0000;
	vlt_loop_cfg_t      cfg;
	logic               velTick, posTick, estimateEn, kpAutoEn, accFfAutoEn, frictionEn;
	logic signed [16:0] integralOut;
	int miscompares = 0;
	int cmpCount = 0;
	int posCnt = 0;
	int mCtl = RST_AUTOTUNE_CTL, mBw = RST_VEL_BW, mKp = RST_KP, mKiM = RST_KI_MAIN;
	int mKiF = RST_KI_FINE, mFbF = RST_FB_FILTER, mFbS = RST_FB_SELECT;
	int mClamp = RST_INT_CLAMP, mOut = RST_OUT_FILTER;
	vlt_addr_t addrs[10] = '{OFS_AUTOTUNE_CTL, OFS_VEL_BW, OFS_KI_COMBINED, OFS_KP,
		OFS_KI_MAIN, OFS_FB_FILTER, OFS_FB_SELECT, OFS_KI_FINE, OFS_INT_CLAMP, OFS_OUT_FILTER};
	int modes[9] = '{0, 1, 2, 4, 10, 11, 12, 14, 3};

	// Short sample periods keep the run small
	vlt_velocity_loop_cfg #(.VEL_CYC_LO_P(40), .VEL_CYC_HI_P(20)) uut (
		.sys_clk(sys_clk), .rstn(rstn), .busReq(busReq), .rdData(rdData),
		.inertiaRatio(inertiaRatio), .moveFwd(moveFwd), .moveRev(moveRev),
		.tuneKpValid(tuneKpValid), .tuneKp(tuneKp), .velError(velError), .cfg(cfg),
		.velTick(velTick), .posTick(posTick), .estimateEn(estimateEn), .kpAutoEn(kpAutoEn),
		.accFfAutoEn(accFfAutoEn), .frictionEn(frictionEn), .integralOut(integralOut));

	always #5 sys_clk = ~sys_clk;

	function automatic int sat(int v, int lo, int hi);
		return (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction : sat

	function automatic int mRead(vlt_addr_t a);
		case (a)
			OFS_AUTOTUNE_CTL: return mCtl;
			OFS_VEL_BW: return mBw;
			OFS_KI_COMBINED: return sat(mKiM * 32 + mKiF, 0, 16384);
			OFS_KP: return mKp;
			OFS_KI_MAIN: return mKiM;
			OFS_FB_FILTER: return mFbF;
			OFS_FB_SELECT: return mFbS;
			OFS_KI_FINE: return mKiF;
			OFS_INT_CLAMP: return mClamp;
			OFS_OUT_FILTER: return mOut;
			default: return 0;
		endcase
	endfunction : mRead

	function automatic vlt_fb_path_t expPath(int m);
		case (m)
			1, 11: return FB_PATH_RAW;
			2, 12: return FB_PATH_OBS;
			4, 14: return FB_PATH_LPF1;
			default: return FB_PATH_LPF2;
		endcase
	endfunction : expPath

	task automatic final_report();
		if (miscompares == 0 && cmpCount > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	task automatic wr(input vlt_addr_t a, input int v);
		@(posedge sys_clk);
		busReq.addr <= a;
		busReq.wdata <= 16'(v);
		busReq.wr <= 1'b1;
		@(posedge sys_clk);
		busReq.wr <= 1'b0;
		case (a)
			OFS_AUTOTUNE_CTL: if (v <= 31) mCtl = v;
			OFS_VEL_BW: begin
				mBw = sat(v, 1, 700);
				mKp = sat((mBw * int'(inertiaRatio)) >> 3, 1, 32767);
			end
			OFS_KI_COMBINED: begin
				mKiM = 0;
				mKiF = sat(v, 0, 16384);
			end
			OFS_KP: mKp = sat(v, 1, 32767);
			OFS_KI_MAIN: mKiM = sat(v, 0, 1023);
			OFS_KI_FINE: mKiF = sat(v, 0, 32767);
			OFS_FB_FILTER: mFbF = sat(v, 0, 45);
			OFS_FB_SELECT: mFbS = v & 255;
			OFS_INT_CLAMP: mClamp = sat(v, 0, 32768);
			OFS_OUT_FILTER: mOut = sat(v, 1, 1370);
			default: ;
		endcase
	endtask : wr

	task automatic rdChk(input vlt_addr_t a);
		@(posedge sys_clk);
		busReq.addr <= a;
		busReq.rd <= 1'b1;
		@(posedge sys_clk);
		busReq.rd <= 1'b0;
		#1;
		`CHK(rdData, 16'(mRead(a)))
	endtask : rdChk

	// Bounded wait; a lost tick ends the run
	task automatic waitTick(output int n);
		for (n = 1; n <= 200; n++) begin
			@(posedge sys_clk);
			#1;
			if (velTick === 1'b1) begin
				if (posTick === 1'b1) posCnt++;
				return;
			end
		end
		miscompares++;
		final_report();
	endtask : waitTick

	task automatic cfgChk();
		int m;
		m = mFbS & 127;
		`CHK(cfg.kp, 16'(mKp))
		`CHK(cfg.kiEff, 17'(mKiM * 32 + mKiF))
		`CHK(cfg.intLimit, 16'(mClamp))
		`CHK(cfg.fbBandwidthHz, 16'(100 + 20 * mFbF))
		`CHK(cfg.outFilterDiv, 16'(mOut))
		`CHK(cfg.fbPath, expPath(m))
		`CHK(cfg.cmdFilterOn, 1'(m == 10 || m == 11 || m == 12 || m == 14))
		`CHK(cfg.cmdSharesFbBw, 1'(m == 10 || m == 14))
		`CHK(cfg.fastRate, 1'(mFbS >> 7))
	endtask : cfgChk

	task automatic pulseTune(input int v);
		@(posedge sys_clk);
		tuneKp <= 16'(v);
		tuneKpValid <= 1'b1;
		@(posedge sys_clk);
		tuneKpValid <= 1'b0;
		if ((mCtl >> 1) & 1) mKp = v;
	endtask : pulseTune

	initial begin
		int n;
		int v;
		int p0;
		vlt_addr_t a;
		logic [15:0] oldKp;
		void'($urandom(32'h8c25b49d));
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		inertiaRatio <= 16'($urandom_range(500, 10));
		foreach (addrs[i]) rdChk(addrs[i]);
		wr(24'h123456, 16'h55aa);
		rdChk(24'h123456);
		repeat (30) begin
			a = addrs[$urandom_range(9, 0)];
			v = (a == OFS_AUTOTUNE_CTL) ? $urandom_range(63, 0) : $urandom_range(65535, 0);
			wr(a, v);
			rdChk(a);
		end
		wr(OFS_KI_COMBINED, 20000);
		rdChk(OFS_KI_COMBINED);
		rdChk(OFS_KI_MAIN);
		wr(OFS_KI_MAIN, 1023);
		wr(OFS_KI_FINE, 32767);
		rdChk(OFS_KI_COMBINED);
		waitTick(n);
		cfgChk();
		oldKp = cfg.kp;
		wr(OFS_KP, $urandom_range(32767, 1));
		`CHK(cfg.kp, oldKp)
		waitTick(n);
		cfgChk();
		foreach (modes[i]) begin
			wr(OFS_FB_SELECT, modes[i] | ($urandom_range(1, 0) << 7));
			waitTick(n);
			cfgChk();
			waitTick(n);
			p0 = posCnt;
			repeat (8) waitTick(n);
			`CHK(n, ((mFbS >> 7) ? 20 : 40))
			`CHK(posCnt - p0, 2)
		end
		wr(OFS_AUTOTUNE_CTL, 2);
		pulseTune($urandom_range(32767, 1));
		rdChk(OFS_KP);
		wr(OFS_AUTOTUNE_CTL, 0);
		pulseTune($urandom_range(32767, 1));
		rdChk(OFS_KP);
		repeat (16) begin
			wr(OFS_AUTOTUNE_CTL, $urandom_range(159, 0));
			moveFwd <= 1'($urandom_range(1, 0));
			moveRev <= 1'($urandom_range(1, 0));
			repeat (2) @(posedge sys_clk);
			#1;
			v = (mCtl & 1) && (moveFwd || moveRev) && !(moveFwd && (mCtl >> 4) & 1)
				&& !(moveRev && (mCtl >> 5) & 1);
			`CHK(estimateEn, 1'(v))
			`CHK(kpAutoEn, 1'(mCtl >> 1))
			`CHK(accFfAutoEn, 1'(mCtl >> 2))
			`CHK(frictionEn, 1'(mCtl >> 7))
		end
		// Large error with a tight clamp must pin the integrator
		v = $urandom_range(100, 1);
		wr(OFS_INT_CLAMP, v);
		velError <= 16'sh7fff;
		repeat (4) waitTick(n);
		@(posedge sys_clk);
		#1;
		`CHK(integralOut, 17'(v))
		@(posedge sys_clk);
		velError <= -16'sh7fff;
		repeat (4) waitTick(n);
		@(posedge sys_clk);
		#1;
		`CHK(integralOut, 17'(-v))
		final_report();
	end
endmodule : vlt_velocity_loop_cfg_tb
